//--- nvdimm_consts.svh
`ifndef NVDIMM_SEQ_CONSTS_SVH
`define NVDIMM_SEQ_CONSTS_SVH

// ****************************************
// Management bus address map
// ****************************************
`define ADDR_CTRL_BASE    7'h10
`define ADDR_TEMP_BASE    7'h18
`define ADDR_PD_PAGE_BASE 7'h30
`define ADDR_PD_RW_BASE   7'h50
`define ADDR_CLKDRV_BASE  7'h58
`define ADDR_RANGE_MASK   7'h78
`define ADDR_STRAP_MASK   7'h07

// ****************************************
// Timing, in the printed units
// ****************************************
`define CLK_HZ            64'd200000000
`define RESP_LIMIT_S      64'd3
`define SAVE_LIMIT_S      64'd75
`define RESTORE_LIMIT_S   64'd65
`define FREE_LIMIT_S      64'd4
`define CHARGE_LIMIT_S    64'd550
`define HANDOVER_LIMIT_US 64'd50
`define CKE_WIN_LIMIT_MS  64'd200
`define US_PER_S          64'd1000000
`define MS_PER_S          64'd1000

// Cycle counts; longest times, so rounded down
`define CYC_RESP     (`RESP_LIMIT_S * `CLK_HZ)
`define CYC_SAVE     (`SAVE_LIMIT_S * `CLK_HZ)
`define CYC_RESTORE  (`RESTORE_LIMIT_S * `CLK_HZ)
`define CYC_FREE     (`FREE_LIMIT_S * `CLK_HZ)
`define CYC_CHARGE   (`CHARGE_LIMIT_S * `CLK_HZ)
`define CYC_HANDOVER (`HANDOVER_LIMIT_US * `CLK_HZ / `US_PER_S)
`define CYC_CKE_WIN  (`CKE_WIN_LIMIT_MS * `CLK_HZ / `MS_PER_S)

`define TIMER_W 40
`define TIMER_ZERO 40'h0
`define TIMER_ONE  40'h1

`endif

//--- nvdimm_pkg.sv
package nvdimm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CKE_WAIT,
    ST_SAVE,
    ST_RESTORE,
    ST_FREE
  } seq_state_t;

  typedef logic [39:0] timer_t;

endpackage

//--- nvdimm_backup_sequencer.sv
`timescale 1ns/1ps
// Operation
// - Decode fixed ranges, low bits match strap
// - Page/protect commands ignore strap, broadcast
// - Respond to bus within three seconds
// - Save finishes within seventy-five seconds
// - Restore finishes within sixty-five seconds
// - Flash freed within four seconds
// - Trigger switches DRAM mux to controller
// - No CKE low in window aborts save
// - CKE check only for qualified sources
// - Accept pin and power-module triggers
// - Ready flag needs all conditions, charge bounded
// - Optional alert low while not ready
`include "nvdimm_consts.svh"
module nvdimm_backup_sequencer
  import nvdimm_pkg::*;
#(
  parameter timer_t RESP_CYC    = timer_t'(`CYC_RESP),
  parameter timer_t SAVE_CYC    = timer_t'(`CYC_SAVE),
  parameter timer_t RESTORE_CYC = timer_t'(`CYC_RESTORE),
  parameter timer_t FREE_CYC    = timer_t'(`CYC_FREE),
  parameter timer_t CHARGE_CYC  = timer_t'(`CYC_CHARGE),
  parameter timer_t HANDOVER_CYC = timer_t'(`CYC_HANDOVER),
  parameter timer_t CKE_CYC     = timer_t'(`CYC_CKE_WIN)
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Management bus address decode
  input  wire logic [2:0] module_select_strap_in,
  input  wire logic       addr_valid_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       ctrl_boot_done_in,
  output logic            bus_respond_out,
  output logic            sel_ctrl_out,
  output logic            sel_temp_out,
  output logic            sel_pd_page_out,
  output logic            sel_pd_rw_out,
  output logic            sel_clkdrv_out,
  // Backup triggers and DRAM control
  input  wire logic       arm_in,
  input  wire logic       disarm_in,
  input  wire logic       save_trigger_n_in,
  input  wire logic       external_power_module_trigger_in,
  input  wire logic       cke_qual_pin_in,
  input  wire logic       cke_qual_ext_in,
  input  wire logic       cke_in,
  output logic            armed_out,
  output logic            mux_to_ctrl_out,
  output logic            save_start_out,
  output logic            save_abort_out,
  // Engine handshakes
  input  wire logic       save_done_in,
  input  wire logic       restore_req_in,
  input  wire logic       restore_done_in,
  input  wire logic       free_flash_req_in,
  input  wire logic       free_flash_done_in,
  output logic            busy_out,
  output logic            op_timeout_out,
  // Readiness and alert
  input  wire logic       charged_in,
  input  wire logic       flash_ok_in,
  input  wire logic       alert_on_not_ready_in,
  output logic            charge_fault_out,
  output logic            backup_ready_flag_out,
  output logic            event_out,
  output logic            event_oe_out
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic in_range(input logic [6:0] a, input logic [6:0] base,
                                    input logic use_strap, input logic [2:0] strap);
    in_range = ((a & `ADDR_RANGE_MASK) == base) &&
               (!use_strap || ((a & `ADDR_STRAP_MASK) == {4'h0, strap}));
  endfunction

  logic resp_q;
  timer_t resp_tmr_q;
  // Fallback guarantees an answer even if boot never signals
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      resp_q     <= 1'b0;
      resp_tmr_q <= `TIMER_ZERO;
    end else if (!resp_q) begin
      resp_tmr_q <= resp_tmr_q + `TIMER_ONE;
      if (ctrl_boot_done_in || resp_tmr_q >= RESP_CYC - `TIMER_ONE) begin
        resp_q <= 1'b1;
      end
    end
  end
  assign bus_respond_out = resp_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sel_ctrl_out    <= 1'b0;
      sel_temp_out    <= 1'b0;
      sel_pd_page_out <= 1'b0;
      sel_pd_rw_out   <= 1'b0;
      sel_clkdrv_out  <= 1'b0;
    end else begin
      sel_ctrl_out    <= addr_valid_in && resp_q &&
                         in_range(addr_in, `ADDR_CTRL_BASE, 1'b1, module_select_strap_in);
      sel_temp_out    <= addr_valid_in && in_range(addr_in, `ADDR_TEMP_BASE, 1'b1, module_select_strap_in);
      sel_pd_rw_out   <= addr_valid_in && in_range(addr_in, `ADDR_PD_RW_BASE, 1'b1, module_select_strap_in);
      sel_clkdrv_out  <= addr_valid_in && in_range(addr_in, `ADDR_CLKDRV_BASE, 1'b1, module_select_strap_in);
      sel_pd_page_out <= addr_valid_in && in_range(addr_in, `ADDR_PD_PAGE_BASE, 1'b0, module_select_strap_in);
    end
  end

  // ****************************************
  // Trigger detection
  // ****************************************
  logic pin_prev_q;
  logic ext_prev_q;
  logic pin_trig;
  logic ext_trig;
  logic trig;
  logic trig_needs_cke;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev_q <= 1'b1;
      ext_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= save_trigger_n_in;
      ext_prev_q <= external_power_module_trigger_in;
    end
  end
  assign pin_trig       = pin_prev_q && !save_trigger_n_in;
  assign ext_trig       = !ext_prev_q && external_power_module_trigger_in;
  assign trig           = pin_trig || ext_trig;
  assign trig_needs_cke = (pin_trig && cke_qual_pin_in) || (ext_trig && cke_qual_ext_in);

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t state_q;
  timer_t     tmr_q;
  logic       armed_q;
  logic       accept;
  logic       cke_expired;
  logic       op_expired;
  assign accept      = (state_q == ST_IDLE) && armed_q && trig;
  assign cke_expired = tmr_q >= CKE_CYC - `TIMER_ONE;
  always_comb begin
    unique case (state_q)
      ST_SAVE:    op_expired = tmr_q >= SAVE_CYC - `TIMER_ONE;
      ST_RESTORE: op_expired = tmr_q >= RESTORE_CYC - `TIMER_ONE;
      ST_FREE:    op_expired = tmr_q >= FREE_CYC - `TIMER_ONE;
      default:    op_expired = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      armed_q <= 1'b0;
    end else if (arm_in) begin
      armed_q <= 1'b1;
    end else if (disarm_in) begin
      armed_q <= 1'b0;
    end
  end
  assign armed_out = armed_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= trig_needs_cke ? ST_CKE_WAIT : ST_SAVE;
          end else if (restore_req_in) begin
            state_q <= ST_RESTORE;
          end else if (free_flash_req_in) begin
            state_q <= ST_FREE;
          end
        end
        ST_CKE_WAIT: begin
          // Host holds self refresh from here on
          if (!cke_in) begin
            state_q <= ST_SAVE;
          end else if (cke_expired) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SAVE:    state_q <= (save_done_in || op_expired) ? ST_IDLE : ST_SAVE;
        ST_RESTORE: state_q <= (restore_done_in || op_expired) ? ST_IDLE : ST_RESTORE;
        ST_FREE:    state_q <= (free_flash_done_in || op_expired) ? ST_IDLE : ST_FREE;
      endcase
    end
  end

  // One timer serves every non-idle state; held at zero in ST_IDLE, restarts on each state change
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tmr_q <= `TIMER_ZERO;
    end else if (state_q == ST_IDLE) begin
      tmr_q <= `TIMER_ZERO;
    end else if (state_q == ST_CKE_WAIT && !cke_in) begin
      tmr_q <= `TIMER_ZERO;
    end else begin
      tmr_q <= tmr_q + `TIMER_ONE;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mux_to_ctrl_out <= 1'b0;
      save_start_out  <= 1'b0;
      save_abort_out  <= 1'b0;
      op_timeout_out  <= 1'b0;
    end else begin
      // Switch one cycle after detect, well inside the handover bound
      if (accept || (state_q == ST_IDLE && (restore_req_in || free_flash_req_in))) begin
        mux_to_ctrl_out <= 1'b1;
      end else if (state_q == ST_IDLE) begin
        mux_to_ctrl_out <= 1'b0;
      end else if (state_q == ST_CKE_WAIT && cke_in && cke_expired) begin
        mux_to_ctrl_out <= 1'b0;
      end
      save_start_out <= (accept && !trig_needs_cke) || (state_q == ST_CKE_WAIT && !cke_in);
      save_abort_out <= state_q == ST_CKE_WAIT && cke_in && cke_expired;
      op_timeout_out <= op_expired;
    end
  end
  assign busy_out = state_q != ST_IDLE;

  // ****************************************
  // Readiness and alert
  // ****************************************
  timer_t chg_tmr_q;
  logic   ready_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      chg_tmr_q        <= `TIMER_ZERO;
      charge_fault_out <= 1'b0;
    end else if (charged_in) begin
      chg_tmr_q        <= `TIMER_ZERO;
      charge_fault_out <= 1'b0;
    end else if (chg_tmr_q >= CHARGE_CYC - `TIMER_ONE) begin
      charge_fault_out <= 1'b1;
    end else begin
      chg_tmr_q <= chg_tmr_q + `TIMER_ONE;
    end
  end
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= charged_in && flash_ok_in && armed_q && resp_q && state_q == ST_IDLE;
    end
  end
  assign backup_ready_flag_out = ready_q;
  assign event_out             = 1'b0;
  assign event_oe_out          = alert_on_not_ready_in && !ready_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_cke_trig;
    state_q == ST_IDLE && accept && trig_needs_cke;
  endsequence
  sequence s_cke_never_low;
    cke_in [*8];
  endsequence
  chk_strap_decode: assert property (addr_valid_in && resp_q && addr_in == {4'h2, module_select_strap_in}
    |=> sel_ctrl_out) else $error("controller address not selected");
  chk_foreign_strap: assert property (addr_valid_in && addr_in[2:0] != module_select_strap_in
    |=> !sel_ctrl_out && !sel_temp_out && !sel_clkdrv_out && !sel_pd_rw_out) else $error("wrong strap selected");
  chk_page_broadcast: assert property (addr_valid_in && addr_in[6:3] == 4'h6
    |=> sel_pd_page_out) else $error("page broadcast missed");
  chk_boot_respond: assert property (ctrl_boot_done_in
    |=> bus_respond_out) else $error("no bus response after boot");
  chk_mux_switch: assert property (accept
    |=> mux_to_ctrl_out) else $error("mux not switched on trigger");
  chk_cke_wait: assert property (s_cke_trig ##1 s_cke_never_low
    |-> !save_start_out) else $error("save started without cke low");
  chk_abort_armed: assert property (save_abort_out && $past(armed_q) && !$past(disarm_in)
    |-> armed_q) else $error("abort disarmed backup");
  chk_direct_save: assert property (accept && !trig_needs_cke
    |=> save_start_out && state_q == ST_SAVE) else $error("unqualified trigger waited on cke");
  chk_pin_trigger: assert property (armed_q && state_q == ST_IDLE && $fell(save_trigger_n_in)
    |=> busy_out) else $error("pin trigger ignored");
  chk_ready_charge: assert property (!charged_in
    |=> !backup_ready_flag_out) else $error("ready while not charged");
  chk_alert_drive: assert property (alert_on_not_ready_in && !backup_ready_flag_out
    |-> event_oe_out) else $error("alert not driven");
  chk_timer_start: assert property (accept
    |=> tmr_q == `TIMER_ZERO) else $error("timer not started at detect");
  chk_op_bound: assert property (op_expired
    |=> op_timeout_out && state_q == ST_IDLE) else $error("timeout not enforced");

endmodule

//--- host_model.sv
`timescale 1ns/1ps
// ****************************************
// Host side: self refresh after bus handover
// ****************************************
module host_model (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // DRAM bus ownership and host behaviour
  input  wire logic mux_in,
  input  wire logic stall_in,
  output logic      cke_out
);
  logic [1:0] wait_q;

  // A stalled host never enters self refresh, which lets the window expire
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q  <= 2'h0;
      cke_out <= 1'b1;
    end else if (!mux_in) begin
      wait_q  <= 2'h0;
      cke_out <= 1'b1;
    end else if (!stall_in) begin
      if (wait_q != 2'h3) wait_q <= wait_q + 2'h1;
      cke_out <= (wait_q != 2'h3);
    end
  end
endmodule

//--- nvdimm_backup_sequencer_test.sv
`timescale 1ns/1ps
// ****************************************
// Bench with shortened timeouts
// ****************************************
module nvdimm_backup_sequencer_test;
  import nvdimm_pkg::*;
  localparam int N = 20;
  logic       clk = 1'b0, rst = 1'b1, av = 1'b0, boot = 1'b0, arm = 1'b0, disarm = 1'b0;
  logic       trig_n = 1'b1, ext = 1'b0, qp = 1'b1, qe = 1'b0, sdone = 1'b0, rreq = 1'b0;
  logic       rdone = 1'b0, freq = 1'b0, fdone = 1'b0, chg = 1'b0, fok = 1'b0, alrt = 1'b0;
  logic       stall = 1'b0;
  logic [2:0] strap = 3'h5;
  logic [6:0] addr = 7'h00;
  wire logic  cke, resp, s_ctrl, s_temp, s_page, s_rw, s_cdrv, armed, mux, start, abort;
  wire logic  busy, tmo, fault, ready, ev, ev_oe;
  int         n_errors = 0, checks_done = 0, n_start = 0, n_abort = 0, n_tmo = 0;
  logic [3:0] hi [5] = '{4'h2, 4'h3, 4'h6, 4'hA, 4'hB};

  nvdimm_backup_sequencer #(.RESP_CYC(timer_t'(N)), .SAVE_CYC(timer_t'(N)), .RESTORE_CYC(timer_t'(N)),
    .FREE_CYC(timer_t'(N)), .CHARGE_CYC(timer_t'(N)), .HANDOVER_CYC(timer_t'(N)), .CKE_CYC(timer_t'(N))) uut (
    .clk_sys_in(clk), .rst_in(rst), .module_select_strap_in(strap), .addr_valid_in(av), .addr_in(addr),
    .ctrl_boot_done_in(boot), .bus_respond_out(resp), .sel_ctrl_out(s_ctrl), .sel_temp_out(s_temp),
    .sel_pd_page_out(s_page), .sel_pd_rw_out(s_rw), .sel_clkdrv_out(s_cdrv), .arm_in(arm), .disarm_in(disarm),
    .save_trigger_n_in(trig_n), .external_power_module_trigger_in(ext), .cke_qual_pin_in(qp),
    .cke_qual_ext_in(qe), .cke_in(cke), .armed_out(armed), .mux_to_ctrl_out(mux), .save_start_out(start),
    .save_abort_out(abort), .save_done_in(sdone), .restore_req_in(rreq), .restore_done_in(rdone),
    .free_flash_req_in(freq), .free_flash_done_in(fdone), .busy_out(busy), .op_timeout_out(tmo),
    .charged_in(chg), .flash_ok_in(fok), .alert_on_not_ready_in(alrt), .charge_fault_out(fault),
    .backup_ready_flag_out(ready), .event_out(ev), .event_oe_out(ev_oe));
  host_model host (.clk_sys_in(clk), .rst_in(rst), .mux_in(mux), .stall_in(stall), .cke_out(cke));

  always #2.5 clk = ~clk;
  // One-cycle pulses are counted so no scenario can miss one
  always @(posedge clk) begin
    if (start === 1'b1) n_start++;
    if (abort === 1'b1) n_abort++;
    if (tmo === 1'b1) n_tmo++;
  end

  task automatic check(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_trigger();
    trig_n = 1'b0;
    step(2);
    trig_n = 1'b1;
  endtask
  task automatic finish_save();
    sdone = 1'b1;
    step(1);
    sdone = 1'b0;
    step(2);
    check(busy, 1'b0);
    check(mux, 1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_respond();
    av = 1'b1;
    addr = 7'h15;
    step(2);
    check(resp, 1'b0);
    check(s_ctrl, 1'b0);
    step(N + 2);
    check(resp, 1'b1);
    check(s_ctrl, 1'b1);
    av = 1'b0;
    boot = 1'b1;
  endtask
  task automatic t_decode();
    logic m;
    for (int b = 0; b < 5; b++) begin
      for (int l = 0; l < 8; l++) begin
        m = (l == int'(strap));
        addr = {hi[b], 3'(l)};
        av = 1'b1;
        step(1);
        check(s_ctrl, b == 0 && m);
        check(s_temp, b == 1 && m);
        check(s_page, b == 2);
        check(s_rw, b == 3 && m);
        check(s_cdrv, b == 4 && m);
      end
    end
    av = 1'b0;
    step(1);
    check(s_page, 1'b0);
  endtask
  task automatic t_qualified();
    int s0;
    s0 = n_start;
    arm = 1'b1;
    step(1);
    arm = 1'b0;
    step(1);
    check(armed, 1'b1);
    pulse_trigger();
    check(mux, 1'b1);
    check(n_start == s0, 1'b1);
    step(6);
    check(n_start == s0 + 1, 1'b1);
    finish_save();
  endtask
  task automatic t_abort();
    int a0, s0;
    a0 = n_abort;
    s0 = n_start;
    stall = 1'b1;
    pulse_trigger();
    step(N - 6);
    check(n_abort == a0, 1'b1);
    step(8);
    check(n_abort == a0 + 1, 1'b1);
    check(mux, 1'b0);
    check(armed, 1'b1);
    stall = 1'b0;
    pulse_trigger();
    step(6);
    check(n_start == s0 + 1, 1'b1);
    finish_save();
  endtask
  task automatic t_unqualified();
    int s0, t0;
    s0 = n_start;
    t0 = n_tmo;
    stall = 1'b1;
    ext = 1'b1;
    step(3);
    check(n_start == s0 + 1, 1'b1);
    check(mux, 1'b1);
    ext = 1'b0;
    step(N - 6);
    check(n_tmo == t0, 1'b1);
    step(8);
    check(n_tmo == t0 + 1, 1'b1);
    check(busy, 1'b0);
    stall = 1'b0;
  endtask
  task automatic t_ops();
    int t0;
    t0 = n_tmo;
    rreq = 1'b1;
    step(1);
    rreq = 1'b0;
    step(1);
    check(busy, 1'b1);
    step(N - 6);
    check(n_tmo == t0, 1'b1);
    step(8);
    check(n_tmo == t0 + 1, 1'b1);
    freq = 1'b1;
    step(1);
    freq = 1'b0;
    step(3);
    check(busy, 1'b1);
    fdone = 1'b1;
    step(1);
    fdone = 1'b0;
    step(2);
    check(busy, 1'b0);
    check(n_tmo == t0 + 1, 1'b1);
  endtask
  task automatic t_ready();
    alrt = 1'b1;
    chg = 1'b1;
    fok = 1'b1;
    step(3);
    check(ready, 1'b1);
    check(ev_oe, 1'b0);
    check(ev, 1'b0);
    fok = 1'b0;
    step(2);
    check(ready, 1'b0);
    check(ev_oe, 1'b1);
    fok = 1'b1;
    chg = 1'b0;
    step(N + 3);
    check(fault, 1'b1);
    chg = 1'b1;
    step(3);
    check(fault, 1'b0);
    check(ready, 1'b1);
    disarm = 1'b1;
    step(1);
    disarm = 1'b0;
    step(2);
    check(ready, 1'b0);
    pulse_trigger();
    check(mux, 1'b0);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    step(10);
    rst = 1'b0;
    t_respond();
    t_decode();
    t_qualified();
    t_abort();
    t_unqualified();
    t_ops();
    t_ready();
    complete_run();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule
